// >>> alx_pkg.sv
// Constants, types and decode helper for the ALU and jump execute block.
// Behaviour
// - and_literal_into_acc: acc AND literal into acc; null flag only.
// - or_literal_into_acc: acc OR literal into acc; null flag only.
// - add_acc_to_file: acc plus file; sets carry, nibble carry, null.
// - and_acc_with_file: acc AND file; updates only null flag.
// - Destination bit 0 selects acc, 1 selects file; 7-bit address.
// - jump_absolute: literal to PC[10:0], latch bits 4:3 to PC[12:11].
// - jump_absolute takes two cycles; literal spans 0 to 2047.
// - bump_skip_if_null: file plus one to destination; flags unchanged.
// - A zero increment result discards the next instruction as idle_op.
`default_nettype none
package alx_pkg;
  localparam logic [7:0]  OFS_INSTR   = 8'h00;
  localparam logic [7:0]  OFS_ACC     = 8'h04;
  localparam logic [7:0]  OFS_STAT    = 8'h08;
  localparam logic [7:0]  OFS_UPPER   = 8'h0c;
  localparam logic [7:0]  OFS_PC      = 8'h10;
  localparam logic [7:0]  OFS_FADDR   = 8'h14;
  localparam logic [7:0]  OFS_FDATA   = 8'h18;
  localparam int          ST_NULL     = 0;
  localparam int          ST_NIBBLE   = 1;
  localparam int          ST_CARRY    = 2;
  localparam int          ST_SKIP     = 3;
  localparam int          ST_BUSY     = 4;
  localparam int          DEST_BIT    = 7;
  localparam int          JUMP_HI     = 4;
  localparam int          JUMP_LO     = 3;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [5:0]  OPC_AND_LITERAL_INTO_ACC   = 6'h39;
  localparam logic [5:0]  OPC_OR_LITERAL_INTO_ACC   = 6'h38;
  localparam logic [5:0]  OPC_ADDWF   = 6'h07;
  localparam logic [5:0]  OPC_AND_ACC_WITH_FILE   = 6'h05;
  localparam logic [5:0]  OPC_INCSKIP = 6'h0f;
  localparam logic [2:0]  OPC_JUMP    = 3'h5;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  UPPER_RST   = 8'h00;
  localparam logic [12:0] PC_RST      = 13'h0000;
  localparam logic [13:0] INSTR_RST   = 14'h0000;
  localparam logic [7:0]  FILE_RST    = 8'h00;

  typedef enum logic [2:0] {
    ALX_OP_IDLE  = 3'b000,
    ALX_OP_AND_LITERAL_INTO_ACC = 3'b001,
    ALX_OP_OR_LITERAL_INTO_ACC = 3'b010,
    ALX_OP_ADDWF = 3'b011,
    ALX_OP_AND_ACC_WITH_FILE = 3'b100,
    ALX_OP_INCSK = 3'b101,
    ALX_OP_JUMP  = 3'b110
  } alx_op_t;

  typedef enum logic [1:0] {
    ALX_IDLE   = 2'b00,
    ALX_EXEC   = 2'b01,
    ALX_SECOND = 2'b10
  } alx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       zero;
    logic       nib;
    logic       carry;
  } alx_res_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } alx_fwr_t;

  // Unknown encodings fall back to idle_op so stray words are harmless.
  function automatic alx_op_t alx_decode(input logic [13:0] ins);
    alx_op_t op;
    op = ALX_OP_IDLE;
    if (ins[13:8] == OPC_AND_LITERAL_INTO_ACC) op = ALX_OP_AND_LITERAL_INTO_ACC;
    if (ins[13:8] == OPC_OR_LITERAL_INTO_ACC) op = ALX_OP_OR_LITERAL_INTO_ACC;
    if (ins[13:8] == OPC_ADDWF) op = ALX_OP_ADDWF;
    if (ins[13:8] == OPC_AND_ACC_WITH_FILE) op = ALX_OP_AND_ACC_WITH_FILE;
    if (ins[13:8] == OPC_INCSKIP) op = ALX_OP_INCSK;
    if (ins[13:11] == OPC_JUMP) op = ALX_OP_JUMP;
    return op;
  endfunction
endpackage
`default_nettype wire

// >>> alx_alu.sv
// Combinational result and flag unit of the execute block.
`timescale 1ns/1ps
`default_nettype none
module alx_alu (
  input  wire alx_pkg::alx_op_t  i_op,
  input  wire logic [7:0]        i_acc,
  input  wire logic [7:0]        i_fval,
  input  wire logic [7:0]        i_lit,
  output alx_pkg::alx_res_t      o_res
);
  wire logic [8:0] sum;
  wire logic [4:0] nsum;
  wire logic [7:0] inc;
  wire logic [7:0] data;

  assign sum  = {1'b0, i_acc} + {1'b0, i_fval};
  assign nsum = {1'b0, i_acc[3:0]} + {1'b0, i_fval[3:0]};
  assign inc  = 8'(i_fval + 8'h01);
  assign data = (i_op == alx_pkg::ALX_OP_AND_LITERAL_INTO_ACC) ? i_acc & i_lit :
                (i_op == alx_pkg::ALX_OP_OR_LITERAL_INTO_ACC) ? i_acc | i_lit :
                (i_op == alx_pkg::ALX_OP_ADDWF) ? sum[7:0] :
                (i_op == alx_pkg::ALX_OP_AND_ACC_WITH_FILE) ? i_acc & i_fval :
                (i_op == alx_pkg::ALX_OP_INCSK) ? inc : i_acc;
  assign o_res = '{data: data, zero: (data == 8'h00),
                   nib: nsum[4], carry: sum[8]};
endmodule
`default_nettype wire

// >>> alx_fregs.sv
// File register storage: 128 bytes with one write and two read ports.
`timescale 1ns/1ps
`default_nettype none
module alx_fregs (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire alx_pkg::alx_fwr_t i_wr,
  input  wire logic [6:0]        i_ra,
  output logic [7:0]             o_rda,
  input  wire logic [6:0]        i_rb,
  output logic [7:0]             o_rdb
);
  logic [7:0] mem_reg [128];

  assign o_rda = mem_reg[i_ra];
  assign o_rdb = mem_reg[i_rb];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < 128; i++) begin
        mem_reg[i] <= alx_pkg::FILE_RST;
      end
    end else if (i_wr.we) begin
      mem_reg[i_wr.addr] <= i_wr.data;
    end
  end
endmodule
`default_nettype wire

// >>> alx_core.sv
// Execute unit for a subset of the 14-bit instruction set, AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module alx_core (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp
);
  alx_pkg::alx_state_t state_reg;
  alx_pkg::alx_state_t state_next;
  logic [13:0]         instr_reg;
  logic [7:0]          acc_reg;
  logic [7:0]          acc_next;
  logic                null_reg;
  logic                null_next;
  logic                nib_reg;
  logic                nib_next;
  logic                carry_reg;
  logic                carry_next;
  logic                skip_reg;
  logic                skip_next;
  logic [7:0]          upper_reg;
  logic [12:0]         pc_reg;
  logic [12:0]         pc_next;
  logic [6:0]          faddr_reg;
  logic                aw_hold_reg;
  logic                aw_hold_next;
  logic                awrdy_reg;
  logic [7:0]          awaddr_reg;
  logic                w_hold_reg;
  logic                w_hold_next;
  logic                wrdy_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arrdy_reg;
  logic                rvalid_reg;
  logic                rvalid_next;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == alx_pkg::OFS_INSTR) || (a == alx_pkg::OFS_ACC) ||
           (a == alx_pkg::OFS_STAT)  || (a == alx_pkg::OFS_UPPER) ||
           (a == alx_pkg::OFS_PC)    || (a == alx_pkg::OFS_FADDR) ||
           (a == alx_pkg::OFS_FDATA);
  endfunction

  logic [7:0] f_bus;
  logic [7:0] f_val;

  // Narrow fields sit in the low bits; the bits above read as zero.
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      alx_pkg::OFS_INSTR: v = {18'h00000, instr_reg};
      alx_pkg::OFS_ACC:   v = {24'h000000, acc_reg};
      alx_pkg::OFS_STAT:  v = {27'h0000000, state_reg != alx_pkg::ALX_IDLE,
                               skip_reg, carry_reg, nib_reg, null_reg};
      alx_pkg::OFS_UPPER: v = {24'h000000, upper_reg};
      alx_pkg::OFS_PC:    v = {19'h00000, pc_reg};
      alx_pkg::OFS_FADDR: v = {25'h0000000, faddr_reg};
      alx_pkg::OFS_FDATA: v = {24'h000000, f_bus};
    endcase
    return v;
  endfunction

  // Bus write path. A write waits while an instruction is in flight, so
  // software never races the execute logic for the same register.
  wire logic        wr_go;
  wire logic [31:0] wmask;
  logic [31:0]      wval;
  wire logic        bw_instr;
  wire logic        bw_acc;
  wire logic        bw_stat;
  wire logic        bw_upper;
  wire logic        bw_pc;
  wire logic        bw_faddr;
  wire logic        bw_fdata;
  wire logic        rd_take;

  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg &&
                 (state_reg == alx_pkg::ALX_IDLE);
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  always_comb wval = (rd_val(awaddr_reg) & ~wmask) | (wdata_reg & wmask);
  assign bw_instr = wr_go && (awaddr_reg == alx_pkg::OFS_INSTR);
  assign bw_acc   = wr_go && (awaddr_reg == alx_pkg::OFS_ACC);
  assign bw_stat  = wr_go && (awaddr_reg == alx_pkg::OFS_STAT);
  assign bw_upper = wr_go && (awaddr_reg == alx_pkg::OFS_UPPER);
  assign bw_pc    = wr_go && (awaddr_reg == alx_pkg::OFS_PC);
  assign bw_faddr = wr_go && (awaddr_reg == alx_pkg::OFS_FADDR);
  assign bw_fdata = wr_go && (awaddr_reg == alx_pkg::OFS_FDATA);

  assign aw_hold_next = !wr_go && (aw_hold_reg || (i_awvalid && awrdy_reg));
  assign w_hold_next  = !wr_go && (w_hold_reg || (i_wvalid && wrdy_reg));
  assign rd_take      = i_arvalid && arrdy_reg;
  assign rvalid_next  = rd_take || (rvalid_reg && !i_rready);

  // Execute path.
  alx_pkg::alx_op_t  ex_op;
  alx_pkg::alx_res_t ex_res;
  alx_pkg::alx_fwr_t fwr;
  wire logic         ex_go;
  wire logic         lit_op;
  wire logic         file_op;
  wire logic         ex_to_acc;
  wire logic         ex_to_file;
  wire logic         ex_nullupd;
  wire logic         ex_arith;
  wire logic [7:0]   ex_data;
  wire logic         ex_zero;
  wire logic [7:0]   lit;
  wire logic         dest;
  wire logic [12:0]  jump_pc;

  assign ex_go   = (state_reg == alx_pkg::ALX_EXEC);
  assign ex_op   = skip_reg ? alx_pkg::ALX_OP_IDLE :
                   alx_pkg::alx_decode(instr_reg);
  assign lit     = instr_reg[7:0];
  assign dest    = instr_reg[alx_pkg::DEST_BIT];
  assign ex_data = ex_res.data;
  assign ex_zero = ex_res.zero;
  assign lit_op  = (ex_op == alx_pkg::ALX_OP_AND_LITERAL_INTO_ACC) ||
                   (ex_op == alx_pkg::ALX_OP_OR_LITERAL_INTO_ACC);
  assign file_op = (ex_op == alx_pkg::ALX_OP_ADDWF) ||
                   (ex_op == alx_pkg::ALX_OP_AND_ACC_WITH_FILE) ||
                   (ex_op == alx_pkg::ALX_OP_INCSK);
  assign ex_to_file = ex_go && file_op && dest;
  assign ex_to_acc  = ex_go && (lit_op || (file_op && !dest));
  assign ex_arith   = ex_go && (ex_op == alx_pkg::ALX_OP_ADDWF);
  assign ex_nullupd = ex_go && (lit_op || (ex_op == alx_pkg::ALX_OP_ADDWF) ||
                      (ex_op == alx_pkg::ALX_OP_AND_ACC_WITH_FILE));
  assign jump_pc = {upper_reg[alx_pkg::JUMP_HI:alx_pkg::JUMP_LO],
                    instr_reg[10:0]};

  assign fwr = '{we:   ex_to_file || bw_fdata,
                 addr: ex_to_file ? instr_reg[6:0] : faddr_reg,
                 data: ex_to_file ? ex_data : wval[7:0]};

  assign acc_next   = ex_to_acc ? ex_data :
                      bw_acc ? wval[7:0] : acc_reg;
  assign null_next  = ex_nullupd ? ex_zero :
                      bw_stat ? wval[alx_pkg::ST_NULL] : null_reg;
  assign nib_next   = ex_arith ? ex_res.nib :
                      bw_stat ? wval[alx_pkg::ST_NIBBLE] : nib_reg;
  assign carry_next = ex_arith ? ex_res.carry :
                      bw_stat ? wval[alx_pkg::ST_CARRY] : carry_reg;
  assign skip_next  = ex_go ? ((ex_op == alx_pkg::ALX_OP_INCSK) && ex_zero) :
                      bw_stat ? wval[alx_pkg::ST_SKIP] : skip_reg;
  assign pc_next    = (ex_go && ex_op == alx_pkg::ALX_OP_JUMP) ? jump_pc :
                      ex_go ? 13'(pc_reg + 13'h0001) :
                      bw_pc ? wval[12:0] : pc_reg;

  // A jump holds the unit for a second cycle, as the refill would.
  always_comb begin
    unique case (state_reg)
      alx_pkg::ALX_IDLE:
        state_next = bw_instr ? alx_pkg::ALX_EXEC : alx_pkg::ALX_IDLE;
      alx_pkg::ALX_EXEC:
        state_next = (ex_op == alx_pkg::ALX_OP_JUMP) ?
                     alx_pkg::ALX_SECOND : alx_pkg::ALX_IDLE;
      alx_pkg::ALX_SECOND:
        state_next = alx_pkg::ALX_IDLE;
      default:
        state_next = alx_pkg::ALX_IDLE;
    endcase
  end

  alx_alu u_alu (
    .i_op   (ex_op),
    .i_acc  (acc_reg),
    .i_fval (f_val),
    .i_lit  (lit),
    .o_res  (ex_res)
  );

  alx_fregs u_fregs (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_wr   (fwr),
    .i_ra   (instr_reg[6:0]),
    .o_rda  (f_val),
    .i_rb   (faddr_reg),
    .o_rdb  (f_bus)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= alx_pkg::ALX_IDLE;
      instr_reg <= alx_pkg::INSTR_RST;
      acc_reg   <= alx_pkg::ACC_RST;
      null_reg  <= 1'b0;
      nib_reg   <= 1'b0;
      carry_reg <= 1'b0;
      skip_reg  <= 1'b0;
      upper_reg <= alx_pkg::UPPER_RST;
      pc_reg    <= alx_pkg::PC_RST;
      faddr_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      instr_reg <= bw_instr ? wval[13:0] : instr_reg;
      acc_reg   <= acc_next;
      null_reg  <= null_next;
      nib_reg   <= nib_next;
      carry_reg <= carry_next;
      skip_reg  <= skip_next;
      upper_reg <= bw_upper ? wval[7:0] : upper_reg;
      pc_reg    <= pc_next;
      faddr_reg <= bw_faddr ? wval[6:0] : faddr_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_hold_reg <= 1'b0;
      awrdy_reg   <= 1'b1;
      awaddr_reg  <= 8'h00;
      w_hold_reg  <= 1'b0;
      wrdy_reg    <= 1'b1;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= alx_pkg::RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      awrdy_reg   <= !aw_hold_next;
      awaddr_reg  <= (i_awvalid && awrdy_reg) ? i_awaddr : awaddr_reg;
      w_hold_reg  <= w_hold_next;
      wrdy_reg    <= !w_hold_next;
      wdata_reg   <= (i_wvalid && wrdy_reg) ? i_wdata : wdata_reg;
      wstrb_reg   <= (i_wvalid && wrdy_reg) ? i_wstrb : wstrb_reg;
      bvalid_reg  <= wr_go || (bvalid_reg && !i_bready);
      bresp_reg   <= !wr_go ? bresp_reg : is_mapped(awaddr_reg) ?
                     alx_pkg::RESP_OKAY : alx_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      arrdy_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= alx_pkg::RESP_OKAY;
    end else begin
      arrdy_reg  <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rd_take ? rd_val(i_araddr) : rdata_reg;
      rresp_reg  <= !rd_take ? rresp_reg : is_mapped(i_araddr) ?
                    alx_pkg::RESP_OKAY : alx_pkg::RESP_SLVERR;
    end
  end

  assign o_awready = awrdy_reg;
  assign o_wready  = wrdy_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_arready = arrdy_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence jump_issue_s;
    ex_go && ex_op == alx_pkg::ALX_OP_JUMP;
  endsequence
  sequence jump_tail_s;
    state_reg == alx_pkg::ALX_SECOND ##1 state_reg == alx_pkg::ALX_IDLE;
  endsequence
  sequence skip_arm_s;
    ex_go && ex_op == alx_pkg::ALX_OP_INCSK && ex_zero;
  endsequence
  sequence skip_use_s;
    ex_go && skip_reg;
  endsequence

  and_literal_a: assert property (
    ex_go && ex_op == alx_pkg::ALX_OP_AND_LITERAL_INTO_ACC |=>
      acc_reg == ($past(acc_reg) & $past(lit)))
    else $error("Literal AND result wrong.");
  or_literal_a: assert property (
    ex_go && ex_op == alx_pkg::ALX_OP_OR_LITERAL_INTO_ACC |=>
      acc_reg == ($past(acc_reg) | $past(lit)) && $stable(carry_reg))
    else $error("Literal OR result wrong.");
  add_flags_a: assert property (
    ex_go && ex_op == alx_pkg::ALX_OP_ADDWF && !dest |=>
      {carry_reg, acc_reg} == 9'($past(acc_reg) + $past(f_val)))
    else $error("Add result or carry wrong.");
  and_file_a: assert property (
    ex_go && ex_op == alx_pkg::ALX_OP_AND_ACC_WITH_FILE |=>
      $stable(carry_reg) && $stable(nib_reg))
    else $error("File AND touched carry flags.");
  dest_route_a: assert property (
    ex_go && file_op && dest |=> $stable(acc_reg))
    else $error("File destination changed accumulator.");
  jump_target_a: assert property (
    jump_issue_s |=> pc_reg == $past(jump_pc) &&
      pc_reg[12:11] == $past(upper_reg[4:3]))
    else $error("Jump target wrong.");
  jump_two_cyc_a: assert property (
    jump_issue_s |=> jump_tail_s)
    else $error("Jump did not take two cycles.");
  bump_flags_a: assert property (
    ex_go && ex_op == alx_pkg::ALX_OP_INCSK |=>
      $stable(null_reg) && $stable(carry_reg) && $stable(nib_reg))
    else $error("Increment changed a flag.");
  skip_arm_a: assert property (skip_arm_s |=> skip_reg)
    else $error("Skip flag was not armed.");
  skip_discard_a: assert property (
    skip_use_s |=> !skip_reg && $stable(acc_reg) && $stable(null_reg))
    else $error("Skipped instruction was not discarded.");
  null_flag_a: assert property (
    ex_nullupd |=> null_reg == ($past(ex_data) == 8'h00))
    else $error("Null flag wrong.");
endmodule
`default_nettype wire

// >>> tb_core_alu_jump_ops_subset.sv
// Self-checking bench for the ALU and jump execute block over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("unexpected %s: expected %h seen %h", nm, (ex), (got)); \
  end \
end

module tb_core_alu_jump_ops_subset;
  logic        i_clk;
  logic        i_nrst;
  logic        i_awvalid;
  logic [7:0]  i_awaddr;
  logic        i_wvalid;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic        i_bready;
  logic        i_arvalid;
  logic [7:0]  i_araddr;
  logic        i_rready;
  logic        o_awready;
  logic        o_wready;
  logic        o_bvalid;
  logic [1:0]  o_bresp;
  logic        o_arready;
  logic        o_rvalid;
  logic [31:0] o_rdata;
  logic [1:0]  o_rresp;
  logic [31:0] rdat;
  logic [1:0]  resp;
  int          err_count;
  int          checks;
  logic [7:0]  rst_ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [7:0]  up      [3] = '{8'h18, 8'h08, 8'he7};
  logic [10:0] jk      [3] = '{11'h7ff, 11'h000, 11'h555};
  logic [12:0] jpc     [3] = '{13'h1fff, 13'h0800, 13'h0555};

  alx_core i_alx_core (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp)
  );

  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;

  // Valid and payload stay up until the edge at which ready is sampled.
  task automatic axi_w(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
    bit aw_ok = 1'b0, w_ok = 1'b0, b_ok = 1'b0;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr  <= a;
    i_wvalid  <= 1'b1;
    i_wdata   <= d;
    i_wstrb   <= s;
    i_bready  <= 1'b1;
    while (!b_ok) begin
      @(posedge i_clk);
      if (!aw_ok && o_awready === 1'b1) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready === 1'b1) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
      if (o_bvalid === 1'b1) begin
        b_ok = 1'b1;
        r = o_bresp;
        i_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_r(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    bit ar_ok = 1'b0, r_ok = 1'b0;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= 1'b1;
    while (!r_ok) begin
      @(posedge i_clk);
      if (!ar_ok && o_arready === 1'b1) begin
        ar_ok = 1'b1;
        i_arvalid <= 1'b0;
      end
      if (o_rvalid === 1'b1) begin
        r_ok = 1'b1;
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_w(a, d, 4'hf, r);
    `CHK("bresp", alx_pkg::RESP_OKAY, r)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_r(a, d, r);
    `CHK("rresp", alx_pkg::RESP_OKAY, r)
    `CHK(nm, e, d)
  endtask

  // Polling busy keeps reads from racing a two-cycle instruction.
  task automatic exec(input logic [13:0] ins);
    logic [31:0] d;
    logic [1:0]  r;
    wr(alx_pkg::OFS_INSTR, {18'h0, ins});
    do begin
      axi_r(alx_pkg::OFS_STAT, d, r);
    end while (d[alx_pkg::ST_BUSY] !== 1'b0);
  endtask

  task automatic fset(input logic [6:0] a, input logic [7:0] v);
    wr(alx_pkg::OFS_FADDR, {25'h0, a});
    wr(alx_pkg::OFS_FDATA, {24'h0, v});
  endtask

  task automatic fchk(input logic [6:0] a, input logic [7:0] e);
    wr(alx_pkg::OFS_FADDR, {25'h0, a});
    rd(alx_pkg::OFS_FDATA, {24'h0, e}, "file");
  endtask

  function automatic logic [13:0] fop(input logic [5:0] op,
                                      input logic dst, input logic [6:0] f);
    return {op, dst, f};
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    conclude();
  end

  initial begin
    i_nrst = 1'b0;
    i_awvalid = 1'b0;
    i_awaddr = 8'h00;
    i_wvalid = 1'b0;
    i_wdata = 32'h0;
    i_wstrb = 4'h0;
    i_bready = 1'b0;
    i_arvalid = 1'b0;
    i_araddr = 8'h00;
    i_rready = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rst_ofs[i]) begin
      rd(rst_ofs[i], 32'h0, "reset value");
    end
    fchk(7'h40, 8'h00);
    axi_r(8'h1c, rdat, resp);
    `CHK("unmapped rresp", alx_pkg::RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0, rdat)
    axi_w(8'h20, 32'h5, 4'hf, resp);
    `CHK("unmapped bresp", alx_pkg::RESP_SLVERR, resp)
    axi_w(alx_pkg::OFS_ACC, 32'hff, 4'he, resp);
    rd(alx_pkg::OFS_ACC, 32'h0, "masked acc");
    wr(alx_pkg::OFS_STAT, 32'h6);
    wr(alx_pkg::OFS_ACC, 32'ha3);
    exec({alx_pkg::OPC_AND_LITERAL_INTO_ACC, 8'h5f});
    rd(alx_pkg::OFS_ACC, 32'h03, "acc");
    rd(alx_pkg::OFS_STAT, 32'h06, "stat");
    exec({alx_pkg::OPC_AND_LITERAL_INTO_ACC, 8'h00});
    rd(alx_pkg::OFS_STAT, 32'h07, "stat");
    wr(alx_pkg::OFS_ACC, 32'h9a);
    exec({alx_pkg::OPC_OR_LITERAL_INTO_ACC, 8'h35});
    rd(alx_pkg::OFS_ACC, 32'hbf, "acc");
    rd(alx_pkg::OFS_STAT, 32'h06, "stat");
    wr(alx_pkg::OFS_ACC, 32'h00);
    exec({alx_pkg::OPC_OR_LITERAL_INTO_ACC, 8'h00});
    rd(alx_pkg::OFS_STAT, 32'h07, "stat");
    wr(alx_pkg::OFS_STAT, 32'h0);
    wr(alx_pkg::OFS_ACC, 32'h17);
    fset(7'h7f, 8'hc2);
    exec(fop(alx_pkg::OPC_ADDWF, 1'b0, 7'h7f));
    rd(alx_pkg::OFS_ACC, 32'hd9, "acc");
    rd(alx_pkg::OFS_STAT, 32'h00, "stat");
    fchk(7'h7f, 8'hc2);
    wr(alx_pkg::OFS_ACC, 32'h88);
    fset(7'h00, 8'h78);
    exec(fop(alx_pkg::OPC_ADDWF, 1'b1, 7'h00));
    fchk(7'h00, 8'h00);
    rd(alx_pkg::OFS_ACC, 32'h88, "acc");
    rd(alx_pkg::OFS_STAT, 32'h07, "stat");
    wr(alx_pkg::OFS_ACC, 32'h0f);
    fset(7'h10, 8'h01);
    exec(fop(alx_pkg::OPC_ADDWF, 1'b1, 7'h10));
    fchk(7'h10, 8'h10);
    rd(alx_pkg::OFS_STAT, 32'h02, "stat");
    wr(alx_pkg::OFS_STAT, 32'h4);
    wr(alx_pkg::OFS_ACC, 32'h17);
    fset(7'h7f, 8'hc2);
    exec(fop(alx_pkg::OPC_AND_ACC_WITH_FILE, 1'b1, 7'h7f));
    fchk(7'h7f, 8'h02);
    rd(alx_pkg::OFS_ACC, 32'h17, "acc");
    rd(alx_pkg::OFS_STAT, 32'h04, "stat");
    wr(alx_pkg::OFS_ACC, 32'h40);
    exec(fop(alx_pkg::OPC_AND_ACC_WITH_FILE, 1'b0, 7'h7f));
    rd(alx_pkg::OFS_ACC, 32'h00, "acc");
    rd(alx_pkg::OFS_STAT, 32'h05, "stat");
    for (int i = 0; i < 3; i++) begin
      wr(alx_pkg::OFS_UPPER, {24'h0, up[i]});
      exec({alx_pkg::OPC_JUMP, jk[i]});
      rd(alx_pkg::OFS_PC, {19'h0, jpc[i]}, "pc");
    end
    wr(alx_pkg::OFS_STAT, 32'h7);
    wr(alx_pkg::OFS_ACC, 32'h5a);
    fset(7'h22, 8'hff);
    exec(fop(alx_pkg::OPC_INCSKIP, 1'b1, 7'h22));
    fchk(7'h22, 8'h00);
    rd(alx_pkg::OFS_STAT, 32'h0f, "stat");
    exec({alx_pkg::OPC_OR_LITERAL_INTO_ACC, 8'h81});
    rd(alx_pkg::OFS_ACC, 32'h5a, "acc");
    rd(alx_pkg::OFS_STAT, 32'h07, "stat");
    rd(alx_pkg::OFS_PC, 32'h0557, "pc");
    fset(7'h22, 8'h41);
    exec(fop(alx_pkg::OPC_INCSKIP, 1'b0, 7'h22));
    rd(alx_pkg::OFS_ACC, 32'h42, "acc");
    fchk(7'h22, 8'h41);
    rd(alx_pkg::OFS_STAT, 32'h07, "stat");
    rd(alx_pkg::OFS_PC, 32'h0558, "pc");
    conclude();
  end
endmodule
`default_nettype wire
